// File: rtl/ppc_pad_ctrl.sv
// Pad control registers for one eight-pin and one four-pin parallel port.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// RQ1 - Wide port pull enable per pin
// RQ2 - Output pins force pull off
// RQ3 - Analog control forces pull off
// RQ4 - Pull select 0 pullup, 1 pulldown
// RQ5 - Pull applied only while enabled
// RQ6 - Wide port slew enable per pin
// RQ7 - Slew ignored while pin is input
// RQ8 - Wide port drive strength per pin
// RQ9 - Narrow port pull enable, same gating
// RQ10 - Narrow port pull select per pin
// RQ11 - Narrow port slew enable per pin
// RQ12 - Never alters direction or data
// RQ13 - Drive bit 1 selects high drive
// RQ14 - Narrow port drive strength per pin
// RQ15 - Direction bit set means output
// RQ16 - All bits reset zero, upper zero
module ppc_pad_ctrl #(
  parameter int WIDE_PINS = 8,
  parameter int NARROW_PINS = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // Classic Wishbone slave.
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  // Port state from the parallel I/O and peripheral logic, same clock.
  input wire logic [WIDE_PINS-1:0] wide_port_direction,
  input wire logic [WIDE_PINS-1:0] wide_periph_out,
  input wire logic [WIDE_PINS-1:0] wide_analog_sel,
  input wire logic [NARROW_PINS-1:0] narrow_port_direction,
  input wire logic [NARROW_PINS-1:0] narrow_periph_out,
  input wire logic [NARROW_PINS-1:0] narrow_analog_sel,
  // Pad controls to the wide port pads.
  output logic [WIDE_PINS-1:0] wide_pullup_on,
  output logic [WIDE_PINS-1:0] wide_pulldown_on,
  output logic [WIDE_PINS-1:0] wide_slew_on,
  output logic [WIDE_PINS-1:0] wide_high_drive,
  // Pad controls to the narrow port pads.
  output logic [NARROW_PINS-1:0] narrow_pullup_on,
  output logic [NARROW_PINS-1:0] narrow_pulldown_on,
  output logic [NARROW_PINS-1:0] narrow_slew_on,
  output logic [NARROW_PINS-1:0] narrow_high_drive
);
  import ppc_pkg::*;

  // ****************************************
  // Register storage
  // ****************************************
  logic [WIDE_PINS-1:0] wide_port_pull_enable_reg; // Pull device enables.
  logic [WIDE_PINS-1:0] wide_port_pull_select_reg; // Pullup or pulldown choice.
  logic [WIDE_PINS-1:0] wide_port_slew_enable_reg; // Slew limiting enables.
  logic [WIDE_PINS-1:0] wide_port_drive_select_reg; // High drive selects.
  logic [NARROW_PINS-1:0] narrow_port_pull_enable_reg; // Pull device enables.
  logic [NARROW_PINS-1:0] narrow_port_pull_select_reg; // Pullup or pulldown choice.
  logic [NARROW_PINS-1:0] narrow_port_slew_enable_reg; // Slew limiting enables.
  logic [NARROW_PINS-1:0] narrow_port_drive_select_reg; // High drive selects.
  logic wr_stb; // Write strobe on the first cycle of a write.
  logic rd_stb; // Read strobe on the first cycle of a read.
  logic lane0; // The low byte lane is selected.
  logic [7:0] wpull; // Pull allowed per wide pin, before the select steers it.
  logic [7:0] npull; // Pull allowed per narrow pin, zero-extended to eight bits.

  // A new access is one not yet acknowledged; this gives ack one cycle low between accesses.
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign lane0 = wb_sel_i[PPC_LANE_LSB];

  // Pad logic drives a pull only when the pin floats as an input.
  function automatic logic [7:0] pull_gate(input logic [7:0] en, input logic [7:0] dir,
                                           input logic [7:0] per, input logic [7:0] ana);
    pull_gate = en & ~dir & ~per & ~ana;
  endfunction

  // ****************************************
  // Pull gating
  // ****************************************
  // Kept combinational so the clocked pad process needs no blocking temporaries.
  assign wpull = pull_gate(8'(wide_port_pull_enable_reg), 8'(wide_port_direction), // RQ2 RQ15
                           8'(wide_periph_out), 8'(wide_analog_sel)); // RQ3
  assign npull = pull_gate(8'(narrow_port_pull_enable_reg), 8'(narrow_port_direction), // RQ9
                           8'(narrow_periph_out), 8'(narrow_analog_sel));

  // ****************************************
  // Bus acknowledge
  // ****************************************
  // Every access, mapped or not, is answered one cycle after it is seen.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Only the low lane carries data; these registers touch no direction or data state.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wide_port_pull_enable_reg <= PPC_RST_VAL[WIDE_PINS-1:0]; // RQ16
      wide_port_pull_select_reg <= PPC_RST_VAL[WIDE_PINS-1:0];
      wide_port_slew_enable_reg <= PPC_RST_VAL[WIDE_PINS-1:0];
      wide_port_drive_select_reg <= PPC_RST_VAL[WIDE_PINS-1:0];
      narrow_port_pull_enable_reg <= PPC_RST_VAL[NARROW_PINS-1:0];
      narrow_port_pull_select_reg <= PPC_RST_VAL[NARROW_PINS-1:0];
      narrow_port_slew_enable_reg <= PPC_RST_VAL[NARROW_PINS-1:0];
      narrow_port_drive_select_reg <= PPC_RST_VAL[NARROW_PINS-1:0];
    end else if (wr_stb && lane0) begin // RQ12
      case (wb_adr_i)
        PPC_OFS_W_PE: begin
          wide_port_pull_enable_reg <= wb_dat_i[WIDE_PINS-1:0]; // RQ1
        end
        PPC_OFS_W_PS: begin
          wide_port_pull_select_reg <= wb_dat_i[WIDE_PINS-1:0]; // RQ4
        end
        PPC_OFS_W_SE: begin
          wide_port_slew_enable_reg <= wb_dat_i[WIDE_PINS-1:0]; // RQ6
        end
        PPC_OFS_W_DS: begin
          wide_port_drive_select_reg <= wb_dat_i[WIDE_PINS-1:0]; // RQ8
        end
        PPC_OFS_N_PE: begin
          narrow_port_pull_enable_reg <= wb_dat_i[NARROW_PINS-1:0]; // RQ9
        end
        PPC_OFS_N_PS: begin
          narrow_port_pull_select_reg <= wb_dat_i[NARROW_PINS-1:0]; // RQ10
        end
        PPC_OFS_N_SE: begin
          narrow_port_slew_enable_reg <= wb_dat_i[NARROW_PINS-1:0]; // RQ11
        end
        PPC_OFS_N_DS: begin
          narrow_port_drive_select_reg <= wb_dat_i[NARROW_PINS-1:0]; // RQ14
        end
        default: begin
          // Unmapped writes are acknowledged and dropped.
        end
      endcase
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Read data is registered with ack; unmapped offsets and upper bits read zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (wb_adr_i)
        PPC_OFS_W_PE: wb_dat_o <= 32'(wide_port_pull_enable_reg);
        PPC_OFS_W_PS: wb_dat_o <= 32'(wide_port_pull_select_reg);
        PPC_OFS_W_SE: wb_dat_o <= 32'(wide_port_slew_enable_reg);
        PPC_OFS_W_DS: wb_dat_o <= 32'(wide_port_drive_select_reg);
        PPC_OFS_N_PE: wb_dat_o <= 32'(narrow_port_pull_enable_reg); // RQ16
        PPC_OFS_N_PS: wb_dat_o <= 32'(narrow_port_pull_select_reg);
        PPC_OFS_N_SE: wb_dat_o <= 32'(narrow_port_slew_enable_reg);
        PPC_OFS_N_DS: wb_dat_o <= 32'(narrow_port_drive_select_reg);
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Pad control outputs
  // ****************************************
  // Registered so pads see glitch-free levels; cost is one cycle of lag.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wide_pullup_on <= '0;
      wide_pulldown_on <= '0;
      wide_slew_on <= '0;
      wide_high_drive <= '0;
      narrow_pullup_on <= '0;
      narrow_pulldown_on <= '0;
      narrow_slew_on <= '0;
      narrow_high_drive <= '0;
    end else begin
      // The select only steers a pull that is already allowed.
      wide_pullup_on <= wpull[WIDE_PINS-1:0] & ~wide_port_pull_select_reg; // RQ5
      wide_pulldown_on <= wpull[WIDE_PINS-1:0] & wide_port_pull_select_reg; // RQ4
      // Slew only matters on a driven pin, so inputs see it off.
      wide_slew_on <= wide_port_slew_enable_reg & (wide_port_direction | wide_periph_out); // RQ7
      wide_high_drive <= wide_port_drive_select_reg; // RQ13
      narrow_pullup_on <= npull[NARROW_PINS-1:0] & ~narrow_port_pull_select_reg; // RQ10
      narrow_pulldown_on <= npull[NARROW_PINS-1:0] & narrow_port_pull_select_reg;
      narrow_slew_on <= narrow_port_slew_enable_reg &
                        (narrow_port_direction | narrow_periph_out); // RQ11
      narrow_high_drive <= narrow_port_drive_select_reg; // RQ14
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // A pin driven by the direction logic must never see either pull device.
  property p_out_no_pull;
    @(posedge mclk) disable iff (sys_rst)
      wide_port_direction[0] |=> !wide_pullup_on[0] && !wide_pulldown_on[0];
  endproperty
  a_out_no_pull: assert property (p_out_no_pull) else $error("Pull on an output pin."); // RQ2

  // An analog function owns the pin, so both pull devices stay off.
  property p_ana_no_pull;
    @(posedge mclk) disable iff (sys_rst)
      narrow_analog_sel[1] |=> !narrow_pullup_on[1] && !narrow_pulldown_on[1];
  endproperty
  a_ana_no_pull: assert property (p_ana_no_pull) else $error("Pull on analog pin."); // RQ3

  // Pullup and pulldown on one pin at once would fight and waste current.
  property p_pull_excl;
    @(posedge mclk) disable iff (sys_rst) (wide_pullup_on & wide_pulldown_on) == '0;
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("Both pulls on."); // RQ4

  // A pulldown may only appear where software enabled and selected it.
  property p_pull_needs_en;
    @(posedge mclk) disable iff (sys_rst)
      $rose(wide_pulldown_on[2]) |-> $past(wide_port_pull_enable_reg[2])
                                     && $past(wide_port_pull_select_reg[2]);
  endproperty
  a_pull_needs_en: assert property (p_pull_needs_en) else $error("Pulldown without enable."); // RQ5

  // A write on the low lane lands in the pull enable register.
  property p_pe_write;
    @(posedge mclk) disable iff (sys_rst)
      wr_stb && lane0 && wb_adr_i == PPC_OFS_W_PE
        |=> wide_port_pull_enable_reg == $past(wb_dat_i[7:0]);
  endproperty
  a_pe_write: assert property (p_pe_write) else $error("Pull enable write lost."); // RQ1

  // An undriven narrow pin must not show slew limiting as on.
  property p_slew_in;
    @(posedge mclk) disable iff (sys_rst)
      !narrow_port_direction[0] && !narrow_periph_out[0] |=> !narrow_slew_on[0];
  endproperty
  a_slew_in: assert property (p_slew_in) else $error("Slew on input pin."); // RQ11

  // Drive strength is passed straight through with one cycle of lag.
  property p_drive;
    @(posedge mclk) disable iff (sys_rst)
      ##1 wide_high_drive == $past(wide_port_drive_select_reg);
  endproperty
  a_drive: assert property (p_drive) else $error("Drive does not follow select."); // RQ13

  // Every new access is answered after one cycle, for one cycle only.
  property p_ack;
    @(posedge mclk) disable iff (sys_rst)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("Ack timing wrong."); // RQ16

  // The narrow registers hold only four bits; the rest must read zero.
  property p_narrow_upper;
    @(posedge mclk) disable iff (sys_rst)
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == PPC_OFS_N_PE |-> wb_dat_o[31:4] == '0;
  endproperty
  a_narrow_upper: assert property (p_narrow_upper) else $error("Upper bits not zero."); // RQ16

  // A peripheral output function also takes the pull away.
  property p_per_no_pull;
    @(posedge mclk) disable iff (sys_rst)
      wide_periph_out[3] |=> !wide_pullup_on[3] && !wide_pulldown_on[3];
  endproperty
  a_per_no_pull: assert property (p_per_no_pull) else $error("Pull on periph pin."); // RQ2

  // Analog ownership gates the wide port pulls as well.
  property p_wana_no_pull;
    @(posedge mclk) disable iff (sys_rst)
      wide_analog_sel[5] |=> !wide_pullup_on[5] && !wide_pulldown_on[5];
  endproperty
  a_wana_no_pull: assert property (p_wana_no_pull) else $error("Wide analog pin pulled."); // RQ3

  // The narrow port gates its pulls on direction exactly as the wide port.
  property p_ndir_no_pull;
    @(posedge mclk) disable iff (sys_rst)
      narrow_port_direction[2] |=> !narrow_pullup_on[2] && !narrow_pulldown_on[2];
  endproperty
  a_ndir_no_pull: assert property (p_ndir_no_pull) else $error("Narrow output pulled."); // RQ9

  // The narrow select steers one device only.
  property p_nexcl;
    @(posedge mclk) disable iff (sys_rst)
      (narrow_pullup_on & narrow_pulldown_on) == '0;
  endproperty
  a_nexcl: assert property (p_nexcl) else $error("Both narrow pulls on."); // RQ10

  // A pullup may only appear where software enabled it with select low.
  property p_pu_needs_en;
    @(posedge mclk) disable iff (sys_rst)
      $rose(wide_pullup_on[6]) |-> $past(wide_port_pull_enable_reg[6])
                                   && !$past(wide_port_pull_select_reg[6]);
  endproperty
  a_pu_needs_en: assert property (p_pu_needs_en) else $error("Pullup without enable."); // RQ5

  // An enabled pull on a free input pin gives exactly one device.
  property p_one_pull;
    @(posedge mclk) disable iff (sys_rst)
      wide_port_pull_enable_reg[1] && !wide_port_direction[1] && !wide_periph_out[1]
        && !wide_analog_sel[1] |=> wide_pullup_on[1] != wide_pulldown_on[1];
  endproperty
  a_one_pull: assert property (p_one_pull) else $error("Enabled pull missing."); // RQ1

  // Slew limiting reaches a driven wide pin when enabled.
  property p_wslew_out;
    @(posedge mclk) disable iff (sys_rst)
      wide_port_slew_enable_reg[4] && wide_port_direction[4] |=> wide_slew_on[4];
  endproperty
  a_wslew_out: assert property (p_wslew_out) else $error("Slew lost on output."); // RQ6

  // A wide input pin shows no slew limiting whatever the enable says.
  property p_wslew_in;
    @(posedge mclk) disable iff (sys_rst)
      !wide_port_direction[7] && !wide_periph_out[7] |=> !wide_slew_on[7];
  endproperty
  a_wslew_in: assert property (p_wslew_in) else $error("Slew on wide input."); // RQ7

  // A cleared drive bit keeps the wide pin at low drive.
  property p_low_drive;
    @(posedge mclk) disable iff (sys_rst)
      !wide_port_drive_select_reg[0] |=> !wide_high_drive[0];
  endproperty
  a_low_drive: assert property (p_low_drive) else $error("High drive not asked."); // RQ8

  // A set narrow drive bit gives high drive on that pin.
  property p_nhigh_drive;
    @(posedge mclk) disable iff (sys_rst)
      narrow_port_drive_select_reg[3] |=> narrow_high_drive[3];
  endproperty
  a_nhigh_drive: assert property (p_nhigh_drive) else $error("Narrow drive lost."); // RQ14

  // A write without the low lane must leave the settings untouched.
  property p_lane_drop;
    @(posedge mclk) disable iff (sys_rst)
      wr_stb && !lane0 |=> $stable(wide_port_pull_enable_reg)
                           && $stable(narrow_port_slew_enable_reg);
  endproperty
  a_lane_drop: assert property (p_lane_drop) else $error("Unlaned write landed."); // RQ1

  // Reset clears settings and pad outputs on the next edge.
  property p_rst_clear;
    @(posedge mclk)
      sys_rst |=> wide_port_pull_enable_reg == '0 && narrow_port_pull_select_reg == '0
                  && wide_pullup_on == '0 && narrow_high_drive == '0;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("Reset left bits set."); // RQ16
endmodule

// File: rtl/ppc_pkg.sv
// Package of register offsets, the reset value and the low lane position for the pad control block.
package ppc_pkg;
  // Register byte offsets on the Wishbone bus.
  localparam logic [4:0] PPC_OFS_W_PE = 5'h00;
  localparam logic [4:0] PPC_OFS_W_PS = 5'h04;
  localparam logic [4:0] PPC_OFS_W_SE = 5'h08;
  localparam logic [4:0] PPC_OFS_W_DS = 5'h0C;
  localparam logic [4:0] PPC_OFS_N_PE = 5'h10;
  localparam logic [4:0] PPC_OFS_N_PS = 5'h14;
  localparam logic [4:0] PPC_OFS_N_SE = 5'h18;
  localparam logic [4:0] PPC_OFS_N_DS = 5'h1C;
  // Reset value of every pad control field.
  localparam logic [7:0] PPC_RST_VAL = 8'h00;
  // Low byte lane position in the data word.
  localparam int PPC_LANE_LSB = 0;
endpackage

// File: verif/tb_top.sv
// Self-checking testbench for the pad control register block.
`timescale 1ns/10ps
module tb_top;
  import ppc_pkg::*;
  // ************************************************************
  // Signals and bench state
  // ************************************************************
  logic mclk, sys_rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [4:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic [7:0] w_dir, w_per, w_ana, w_pu, w_pd, w_sl, w_hd;
  logic [3:0] n_dir, n_per, n_ana, n_pu, n_pd, n_sl, n_hd;
  logic [31:0] seed = 32'h4D89BB31; // Fixed start keeps every run repeatable.
  logic [7:0] sh [8]; // Shadow copy of what software wrote, masked to the field width.
  logic [4:0] ofs [8] = '{PPC_OFS_W_PE, PPC_OFS_W_PS, PPC_OFS_W_SE, PPC_OFS_W_DS,
                          PPC_OFS_N_PE, PPC_OFS_N_PS, PPC_OFS_N_SE, PPC_OFS_N_DS};
  logic [31:0] exp_q [$]; // Expected read data, oldest first.
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  ppc_pad_ctrl uut (.mclk(mclk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wide_port_direction(w_dir),
    .wide_periph_out(w_per), .wide_analog_sel(w_ana), .narrow_port_direction(n_dir),
    .narrow_periph_out(n_per), .narrow_analog_sel(n_ana), .wide_pullup_on(w_pu),
    .wide_pulldown_on(w_pd), .wide_slew_on(w_sl), .wide_high_drive(w_hd),
    .narrow_pullup_on(n_pu), .narrow_pulldown_on(n_pd), .narrow_slew_on(n_sl),
    .narrow_high_drive(n_hd));
  // ************************************************************
  // Helpers
  // ************************************************************
  // Xorshift generator; the state is shared, so calls advance one stream.
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Compares one value and reports a difference at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
      fails++;
    end
  endtask
  // Prints the verdict and stops; the only place the run ends.
  task automatic complete_run();
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One classic Wishbone cycle; the request is held until ack is sampled high.
  task automatic wb_xfer(input logic [4:0] a, input logic [31:0] d, input logic [3:0] sel,
                         input logic we);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    wb_we_i <= we;
    @(posedge mclk);
    while (wb_ack_o !== 1'b1) @(posedge mclk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // A read notes its expectation first so the monitor can pair it with the answer.
  task automatic wb_read(input int i);
    exp_q.push_back({24'h000000, sh[i]});
    wb_xfer(ofs[i], 32'h00000000, 4'hF, 1'b0);
  endtask
  // Pad outputs follow from the shadow registers and the pin state inputs.
  task automatic pad_check();
    logic [7:0] wp;
    logic [3:0] np;
    wp = sh[0] & ~w_dir & ~w_per & ~w_ana;
    np = sh[4][3:0] & ~n_dir & ~n_per & ~n_ana;
    check(w_pu, wp & ~sh[1], "wide pullup");
    check(w_pd, wp & sh[1], "wide pulldown");
    check(w_sl, sh[2] & (w_dir | w_per), "wide slew");
    check(w_hd, sh[3], "wide drive");
    check(n_pu, np & ~sh[5][3:0], "narrow pullup");
    check(n_pd, np & sh[5][3:0], "narrow pulldown");
    check(n_sl, sh[6][3:0] & (n_dir | n_per), "narrow slew");
    check(n_hd, sh[7][3:0], "narrow drive");
  endtask
  // ************************************************************
  // Clock, monitor and timeout
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Takes the oldest noted read whenever a read is acknowledged.
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() > 0) check(wb_dat_o, exp_q.pop_front(), "read data");
      else check(32'h00000001, 32'h00000000, "unexpected read ack");
    end
  end
  // The whole sequence needs about 1300 cycles; this ceiling catches a hung bus.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      complete_run();
    end
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    {w_dir, w_per, w_ana, n_dir, n_per, n_ana} = '0;
    for (int i = 0; i < 8; i++) sh[i] = PPC_RST_VAL;
    sys_rst = 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    // Every register and pad output starts cleared.
    for (int i = 0; i < 8; i++) wb_read(i);
    pad_check();
    // A write without the low byte lane must be dropped.
    wb_xfer(ofs[0], 32'h000000FF, 4'hE, 1'b0 | 1'b1);
    wb_read(0);
    // Random register contents and pin states; odd rounds clear the direction bits so pulls show.
    for (int r = 0; r < 24; r++) begin
      for (int i = 0; i < 8; i++) begin
        logic [31:0] v;
        v = xs();
        sh[i] = (i >= 4) ? {4'h0, v[3:0]} : v[7:0];
        wb_xfer(ofs[i], v, 4'h1 | v[11:8], 1'b1);
      end
      begin
        logic [31:0] v;
        v = xs();
        w_dir <= r[0] ? 8'h00 : v[7:0];
        w_per <= v[15:8] & v[23:16];
        w_ana <= v[23:16] & v[31:24];
        n_dir <= r[0] ? 4'h0 : v[27:24];
        n_per <= v[3:0] & v[11:8];
        n_ana <= v[19:16] & v[31:28];
      end
      repeat (3) @(posedge mclk);
      pad_check();
      for (int i = 0; i < 8; i++) wb_read(i);
    end
    // A second reset in mid-run clears every register and pad output again.
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) sh[i] = PPC_RST_VAL;
    // Unmapped offsets are answered, drop writes and read zero.
    wb_xfer(5'h1E, 32'h000000FF, 4'hF, 1'b1);
    exp_q.push_back(32'h00000000);
    wb_xfer(5'h1E, 32'h00000000, 4'hF, 1'b0);
    for (int i = 0; i < 8; i++) wb_read(i);
    repeat (2) @(posedge mclk);
    pad_check();
    repeat (2) @(posedge mclk);
    check(exp_q.size(), 0, "reads left unanswered");
    complete_run();
  end
endmodule
